// >>> rtl/csmc_pkg.sv
// Package with register map, field layout and reset values for clock source mode control
// Operation
// - PLL power 00b runs, 01b powers down
// - Source bit 1 oscillator, 0 external input
// - Bypass bit 0 uses divider, 1 bypasses
// - Reset: PLL off, code 000b, external source
// - Calibrate bit plus update strobe starts calibration
// - Polarity bit 0 positive, 1 negative
// - Divider path accepts external input to 2400MHz
// - External source keeps internal oscillator off
// - Three-bit field enables reference input buffers
// - Configuration saved, restored at power-up
package csmc_pkg;

  localparam int AW = 10;
  localparam int DW = 8;
  localparam int NREG = 5;

  localparam logic [AW-1:0] OFF_PLL_CTRL = 10'h010;
  localparam logic [AW-1:0] OFF_OSC_CAL  = 10'h018;
  localparam logic [AW-1:0] OFF_REF_EN   = 10'h01c;
  localparam logic [AW-1:0] OFF_DIV      = 10'h1e0;
  localparam logic [AW-1:0] OFF_SRC_SEL  = 10'h1e1;
  localparam logic [AW-1:0] OFF_UPDATE   = 10'h232;

  // Index of each stored register in the staging and nonvolatile arrays
  localparam int IDX_PLL = 0;
  localparam int IDX_CAL = 1;
  localparam int IDX_REF = 2;
  localparam int IDX_DIV = 3;
  localparam int IDX_SRC = 4;
  localparam logic [NREG-1:0][AW-1:0] REG_OFFS =
    {OFF_SRC_SEL, OFF_DIV, OFF_REF_EN, OFF_OSC_CAL, OFF_PLL_CTRL};

  // Field positions
  localparam int PLL_PWR_LSB = 0;
  localparam int PFD_POL_BIT = 7;
  localparam int CAL_BIT     = 0;
  localparam int REF_EN_LSB  = 0;
  localparam int DIV_LSB     = 0;
  localparam int BYPASS_BIT  = 0;
  localparam int SRC_BIT     = 1;
  localparam int UPD_BIT     = 0;
  localparam int BUSY_BIT    = 1;

  localparam logic [1:0] PLL_RUN  = 2'h0;
  localparam logic [1:0] PLL_DOWN = 2'h1;

  // Reset values
  localparam logic [DW-1:0] RST_PLL = 8'h01;
  localparam logic [DW-1:0] RST_CAL = 8'h00;
  localparam logic [DW-1:0] RST_REF = 8'h00;
  localparam logic [DW-1:0] RST_DIV = 8'h00;
  localparam logic [DW-1:0] RST_SRC = 8'h00;

  // Frequency limits of the clock path, in MHz
  localparam int DIST_MAX_MHZ   = 1600;
  localparam int CLK_IN_MAX_MHZ = 2400;

  // Cycles the strap input needs to pass its synchroniser after reset
  localparam logic [2:0] BOOT_CYCLES = 3'h2;

  typedef logic [NREG-1:0][DW-1:0] csmc_cfg_t;

  typedef enum logic [1:0] {
    ST_BOOT    = 2'b00,
    ST_RESTORE = 2'b01,
    ST_RUN     = 2'b10,
    ST_SAVE    = 2'b11
  } csmc_st_t;

  typedef struct packed {
    logic [1:0] pll_pwr;
    logic       pll_pd;
    logic       pfd_neg;
    logic [2:0] ref_en;
    logic [2:0] div_code;
    logic [2:0] div_ratio;
    logic       src_osc;
    logic       bypass;
    logic       osc_pwr;
  } csmc_route_t;

endpackage

// >>> rtl/csmc_nv_store.sv
// Nonvolatile configuration store with registered read data
`timescale 1ns/1ps
module csmc_nv_store
  import csmc_pkg::*;
#(
  parameter int DEPTH = NREG,
  parameter int WIDTH = DW
) (
  input  wire logic                     clk_i,
  input  wire logic                     rstn_i,
  input  wire logic                     we_i,
  input  wire logic [$clog2(DEPTH)-1:0] waddr_i,
  input  wire logic [WIDTH-1:0]         wdata_i,
  input  wire logic [$clog2(DEPTH)-1:0] raddr_i,
  output logic      [WIDTH-1:0]         rdata_o
);

  // Contents have no reset: they must survive a chip reset
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [WIDTH-1:0] rdata_r;

  always_ff @(posedge clk_i)
  begin
    if (we_i)
    begin
      mem_r[waddr_i] <= wdata_i;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      rdata_r <= '0;
    end
    else
    begin
      rdata_r <= mem_r[raddr_i];
    end
  end

  assign rdata_o = rdata_r;

endmodule // csmc_nv_store

// >>> rtl/csmc_top.sv
// Clock source mode configuration: staged registers, update strobe, routing and store
`timescale 1ns/1ps
module csmc_top
  import csmc_pkg::*;
(
  input  wire logic           clk_i,
  input  wire logic           rstn_i,
  input  wire logic [AW-1:0]  reg_addr_i,
  input  wire logic [DW-1:0]  reg_wdata_i,
  input  wire logic           reg_we_i,
  output logic      [DW-1:0]  reg_rdata_o,
  input  wire logic           nv_save_i,
  input  wire logic           nv_restore_i,
  output logic                busy_o,
  output logic                cal_start_o,
  output csmc_route_t         route_o
);

  typedef struct packed {
    csmc_st_t   st;
    logic [2:0] cnt;
    logic [1:0] sync;
    logic [1:0] save_sync;
    csmc_cfg_t  stage;
    csmc_cfg_t  act;
    logic       cal_pulse;
    logic [DW-1:0] rdata;
  } csmc_state_t;

  localparam csmc_cfg_t CFG_RST = {RST_SRC, RST_DIV, RST_REF, RST_CAL, RST_PLL};

  csmc_state_t     s_r;
  csmc_state_t     s_nxt;
  logic [NREG-1:0] hit;
  logic            upd_hit;
  logic [DW-1:0]   nv_rdata;
  logic            nv_we;
  logic [2:0]      nv_raddr;
  logic [DW-1:0]   rd_mux;

  genvar g;
  generate
    for (g = 0; g < NREG; g++)
    begin : g_dec
      assign hit[g] = (reg_addr_i == REG_OFFS[g]);
    end
  endgenerate

  assign upd_hit = reg_we_i && (reg_addr_i == OFF_UPDATE) && reg_wdata_i[UPD_BIT]
                   && (s_r.st == ST_RUN) && !s_r.save_sync[1];
  assign nv_we    = (s_r.st == ST_SAVE);
  assign nv_raddr = s_r.cnt;

  csmc_nv_store #(
    .DEPTH (NREG),
    .WIDTH (DW)
  ) u_nv (
    .clk_i   (clk_i),
    .rstn_i  (rstn_i),
    .we_i    (nv_we),
    .waddr_i (s_r.cnt),
    .wdata_i (s_r.act[s_r.cnt]),
    .raddr_i (nv_raddr),
    .rdata_o (nv_rdata)
  );

  always_comb
  begin
    rd_mux = '0;
    for (int i = 0; i < NREG; i++)
    begin
      if (hit[i])
      begin
        rd_mux = s_r.stage[i];
      end
    end
    if (reg_addr_i == OFF_UPDATE)
    begin
      rd_mux[BUSY_BIT] = (s_r.st != ST_RUN);
    end
  end

  always_comb
  begin
    s_nxt      = s_r;
    s_nxt.sync = {s_r.sync[0], nv_restore_i};
    // Save request is a pin, so it crosses two flops like the strap
    s_nxt.save_sync = {s_r.save_sync[0], nv_save_i};
    s_nxt.rdata = rd_mux;
    case (s_r.st)
      ST_BOOT:
      begin
        s_nxt.cnt = s_r.cnt + 3'h1;
        if (s_r.cnt == BOOT_CYCLES)
        begin
          s_nxt.cnt = '0;
          s_nxt.st  = s_r.sync[1] ? ST_RESTORE : ST_RUN;
        end
      end
      ST_RESTORE:
      begin
        // Read data trails the address by one cycle
        s_nxt.cnt = s_r.cnt + 3'h1;
        if (s_r.cnt != 3'h0)
        begin
          s_nxt.stage[s_r.cnt - 3'h1] = nv_rdata;
          s_nxt.act[s_r.cnt - 3'h1]   = nv_rdata;
        end
        if (s_r.cnt == 3'(NREG))
        begin
          s_nxt.cnt = '0;
          s_nxt.st  = ST_RUN;
        end
      end
      ST_RUN:
      begin
        // Register writes and saves are refused outside this state
        if (s_r.save_sync[1])
        begin
          s_nxt.cnt = '0;
          s_nxt.st  = ST_SAVE;
        end
        else if (reg_we_i)
        begin
          for (int i = 0; i < NREG; i++)
          begin
            if (hit[i])
            begin
              s_nxt.stage[i] = reg_wdata_i;
            end
          end
          if (upd_hit)
          begin
            s_nxt.act = s_r.stage;
          end
        end
      end
      ST_SAVE:
      begin
        s_nxt.cnt = s_r.cnt + 3'h1;
        if (s_r.cnt == 3'(NREG - 1))
        begin
          s_nxt.cnt = '0;
          s_nxt.st  = ST_RUN;
        end
      end
      default:
      begin
        s_nxt.st = ST_BOOT;
      end
    endcase
    // Only a 0 to 1 change of the applied bit starts calibration, so a stale 1 does not
    s_nxt.cal_pulse = s_nxt.act[IDX_CAL][CAL_BIT] && !s_r.act[IDX_CAL][CAL_BIT];
  end

  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      s_r.st        <= ST_BOOT;
      s_r.cnt       <= '0;
      s_r.sync      <= '0;
      s_r.save_sync <= '0;
      s_r.stage     <= CFG_RST;
      s_r.act       <= CFG_RST;
      s_r.cal_pulse <= 1'b0;
      s_r.rdata     <= '0;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  always_comb
  begin
    route_o.pll_pwr   = s_r.act[IDX_PLL][PLL_PWR_LSB +: 2];
    route_o.pll_pd    = (s_r.act[IDX_PLL][PLL_PWR_LSB +: 2] == PLL_DOWN);
    route_o.pfd_neg   = s_r.act[IDX_PLL][PFD_POL_BIT];
    route_o.ref_en    = s_r.act[IDX_REF][REF_EN_LSB +: 3];
    route_o.div_code  = s_r.act[IDX_DIV][DIV_LSB +: 3];
    // Codes above 4 pass the source undivided
    route_o.div_ratio = (route_o.div_code <= 3'h4) ? route_o.div_code + 3'h2 : 3'h1;
    route_o.src_osc   = s_r.act[IDX_SRC][SRC_BIT];
    // Divider stays in path for inputs up to the external limit
    route_o.bypass    = s_r.act[IDX_SRC][BYPASS_BIT];
    route_o.osc_pwr   = s_r.act[IDX_SRC][SRC_BIT];
  end

  assign reg_rdata_o = s_r.rdata;
  assign busy_o      = (s_r.st != ST_RUN);
  assign cal_start_o = s_r.cal_pulse;

  sequence s_cal_req;
    upd_hit && s_r.stage[IDX_CAL][CAL_BIT] && !s_r.act[IDX_CAL][CAL_BIT];
  endsequence

  sequence s_cal_pulse;
    cal_start_o ##1 !cal_start_o;
  endsequence

  property p_update_applies;
    @(posedge clk_i) disable iff (!rstn_i)
    upd_hit |=> (s_r.act == $past(s_r.stage));
  endproperty
  a_update_applies: assert property (p_update_applies)
    else $error("update strobe did not apply staged values");

  property p_no_update_hold;
    @(posedge clk_i) disable iff (!rstn_i)
    (s_r.st == ST_RUN && !upd_hit) |=> $stable(s_r.act);
  endproperty
  a_no_update_hold: assert property (p_no_update_hold)
    else $error("applied config changed without update");

  property p_reset_values;
    @(posedge clk_i) disable iff (!rstn_i)
    $rose(rstn_i) |-> (route_o.pll_pd && route_o.div_code == 3'h0
                       && !route_o.bypass && !route_o.src_osc);
  endproperty
  a_reset_values: assert property (p_reset_values)
    else $error("wrong state after reset");

  property p_cal_start;
    @(posedge clk_i) disable iff (!rstn_i)
    s_cal_req |=> s_cal_pulse;
  endproperty
  a_cal_start: assert property (p_cal_start)
    else $error("calibration not started after update");

  property p_no_recal;
    @(posedge clk_i) disable iff (!rstn_i)
    cal_start_o |-> !$past(s_r.act[IDX_CAL][CAL_BIT]);
  endproperty
  a_no_recal: assert property (p_no_recal)
    else $error("calibration restarted without clear");

  property p_osc_off;
    @(posedge clk_i) disable iff (!rstn_i)
    !s_r.act[IDX_SRC][SRC_BIT] |-> !route_o.osc_pwr;
  endproperty
  a_osc_off: assert property (p_osc_off)
    else $error("oscillator powered with external source");

  property p_div_two;
    @(posedge clk_i) disable iff (!rstn_i)
    (route_o.div_code == 3'h0) |-> (route_o.div_ratio == 3'h2);
  endproperty
  a_div_two: assert property (p_div_two)
    else $error("code zero not divide by two");

  property p_pll_state;
    @(posedge clk_i) disable iff (!rstn_i)
    upd_hit ##1 (s_r.act[IDX_PLL][1:0] == PLL_RUN) |-> !route_o.pll_pd;
  endproperty
  a_pll_state: assert property (p_pll_state)
    else $error("PLL held down while field is run");

  property p_busy_refuse;
    @(posedge clk_i) disable iff (!rstn_i)
    (s_r.st != ST_RUN) |=> $stable(s_r.stage) || $past(s_r.st == ST_RESTORE);
  endproperty
  a_busy_refuse: assert property (p_busy_refuse)
    else $error("staging written while busy");

  property p_save_len;
    @(posedge clk_i) disable iff (!rstn_i)
    (s_r.st == ST_RUN && s_r.save_sync[1]) |=> busy_o [*5] ##1 !busy_o;
  endproperty
  a_save_len: assert property (p_save_len)
    else $error("save did not last five cycles");

endmodule // csmc_top

// >>> verification/csmc_top_tb.sv
// Self-checking testbench for the clock source mode configuration block
`timescale 1ns/1ps
module csmc_top_tb import csmc_pkg::*; ;
  logic          clk_i;
  logic          rstn_i;
  logic [AW-1:0] reg_addr_i;
  logic [DW-1:0] reg_wdata_i;
  logic          reg_we_i;
  logic [DW-1:0] reg_rdata_o;
  logic          nv_save_i;
  logic          nv_restore_i;
  logic          busy_o;
  logic          cal_start_o;
  csmc_route_t   route_o;
  int            err_count;
  int            total_checks;
  int            cycles;
  int            stage [NREG];
  int            appl [NREG];
  int            nv [NREG];
  int            rst_vals [NREG];
  logic          exp_cal;
  int            n;
  int            k;
  int            j;

  csmc_top u_dut (
    .clk_i        (clk_i),
    .rstn_i       (rstn_i),
    .reg_addr_i   (reg_addr_i),
    .reg_wdata_i  (reg_wdata_i),
    .reg_we_i     (reg_we_i),
    .reg_rdata_o  (reg_rdata_o),
    .nv_save_i    (nv_save_i),
    .nv_restore_i (nv_restore_i),
    .busy_o       (busy_o),
    .cal_start_o  (cal_start_o),
    .route_o      (route_o)
  );

  initial
  begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  // Hang guard, far above the few hundred cycles the sequence needs
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      err_count++;
      $display("mismatch timeout expected done seen hang");
      test_done();
    end
  end

  function automatic logic [31:0] exp_route();
    csmc_route_t r;
    r.pll_pwr   = appl[IDX_PLL][1:0];
    r.pll_pd    = (appl[IDX_PLL][1:0] == PLL_DOWN);
    r.pfd_neg   = appl[IDX_PLL][PFD_POL_BIT];
    r.ref_en    = appl[IDX_REF][2:0];
    r.div_code  = appl[IDX_DIV][2:0];
    r.div_ratio = (appl[IDX_DIV][2:0] <= 3'h4) ? 3'(appl[IDX_DIV][2:0] + 3'h2) : 3'h1;
    r.src_osc   = appl[IDX_SRC][SRC_BIT];
    r.bypass    = appl[IDX_SRC][BYPASS_BIT];
    r.osc_pwr   = appl[IDX_SRC][SRC_BIT];
    return 32'(r);
  endfunction

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // One write; an update write also checks the applied result just after the taking edge
  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge clk_i);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_we_i    <= 1'b1;
    @(posedge clk_i);
    reg_we_i    <= 1'b0;
    for (int i = 0; i < NREG; i++)
      if (a == REG_OFFS[i])
        stage[i] = d;
    if (a == OFF_UPDATE && d[UPD_BIT])
    begin
      exp_cal = (appl[IDX_CAL][CAL_BIT] == 0) && (stage[IDX_CAL][CAL_BIT] == 1);
      appl = stage;
      #1;
      chk("cal_start_o", 32'(exp_cal), 32'(cal_start_o));
      chk("route_o", exp_route(), 32'(route_o));
    end
  endtask

  task automatic rd(input logic [AW-1:0] a, input int exp);
    @(posedge clk_i);
    reg_addr_i <= a;
    @(posedge clk_i);
    #1;
    chk("reg_rdata_o", 32'(exp), 32'(reg_rdata_o));
  endtask

  // Reset, try a write while booting, then wait for the boot to finish
  task automatic do_reset(input logic restore);
    @(posedge clk_i);
    rstn_i       <= 1'b0;
    nv_restore_i <= restore;
    @(posedge clk_i);
    #1;
    appl = rst_vals;
    chk("route_o", exp_route(), 32'(route_o));
    chk("busy_o", 32'(1'b1), 32'(busy_o));
    @(posedge clk_i);
    rstn_i <= 1'b1;
    wr(OFF_PLL_CTRL, 8'hfe);
    #1;
    for (k = 0; k < 40 && busy_o !== 1'b0; k++)
    begin
      @(posedge clk_i);
      #1;
    end
    chk("boot_done", 32'(1), 32'(k < 40));
    stage = restore ? nv : rst_vals;
    appl  = stage;
    chk("route_o", exp_route(), 32'(route_o));
    rd(OFF_PLL_CTRL, stage[IDX_PLL]);
  endtask

  initial
  begin
    rstn_i       = 1'b0;
    reg_addr_i   = '0;
    reg_wdata_i  = '0;
    reg_we_i     = 1'b0;
    nv_save_i    = 1'b0;
    nv_restore_i = 1'b0;
    err_count    = 0;
    total_checks = 0;
    cycles       = 0;
    n            = $urandom(32'h268c_c05f);
    rst_vals     = '{RST_PLL, RST_CAL, RST_REF, RST_DIV, RST_SRC};
    do_reset(1'b0);
    rd(OFF_UPDATE, 0);
    rd(10'h3ff, 0);
    // Every power code, polarity, divider code and source or bypass setting
    for (j = 0; j < 8; j++)
    begin
      wr(OFF_PLL_CTRL, {j[2], 5'h00, j[1:0]});
      wr(OFF_DIV, 8'(j));
      wr(OFF_SRC_SEL, 8'(j[1:0]));
      wr(OFF_REF_EN, 8'(7 - j));
      wr(OFF_UPDATE, 8'h01);
    end
    // Calibration starts only on a rising applied bit
    wr(OFF_OSC_CAL, 8'h01);
    wr(OFF_UPDATE, 8'h01);
    wr(OFF_UPDATE, 8'h01);
    wr(OFF_OSC_CAL, 8'h00);
    wr(OFF_UPDATE, 8'h01);
    wr(OFF_OSC_CAL, 8'h01);
    wr(OFF_UPDATE, 8'h01);
    // Random configurations: staged values must not reach the route early
    for (j = 0; j < 24; j++)
    begin
      for (k = 0; k < NREG; k++)
        wr(REG_OFFS[k], 8'($urandom));
      @(posedge clk_i);
      #1;
      chk("route_o", exp_route(), 32'(route_o));
      k = $urandom % NREG;
      rd(REG_OFFS[k], stage[k]);
      wr(OFF_UPDATE, 8'h01);
    end
    // Mode walk: PLL on with external source through the divider, slow-input bypass,
    // then the oscillator as source with its calibration
    wr(OFF_PLL_CTRL, 8'h00);
    wr(OFF_SRC_SEL, 8'h00);
    wr(OFF_OSC_CAL, 8'h00);
    wr(OFF_UPDATE, 8'h01);
    wr(OFF_SRC_SEL, 8'h01);
    wr(OFF_UPDATE, 8'h01);
    wr(OFF_SRC_SEL, 8'h02);
    wr(OFF_OSC_CAL, 8'h01);
    wr(OFF_UPDATE, 8'h01);
    // Save a known image, disturb it, then restore it through a reset
    wr(OFF_OSC_CAL, 8'h00);
    wr(OFF_UPDATE, 8'h01);
    nv = appl;
    @(posedge clk_i);
    nv_save_i <= 1'b1;
    @(posedge clk_i);
    nv_save_i <= 1'b0;
    n = 0;
    for (k = 0; k < 10; k++)
    begin
      #1;
      if (busy_o === 1'b1)
        n++;
      @(posedge clk_i);
    end
    chk("save_busy", 32'(NREG), 32'(n));
    wr(OFF_DIV, 8'(~nv[IDX_DIV]));
    wr(OFF_UPDATE, 8'h01);
    do_reset(1'b1);
    test_done();
  end
endmodule // csmc_top_tb
